// ==== design/gpdl_port.sv ====
// Our own choice: the AXI4-Lite interface to the registers.
`timescale 1ns/1ps
`default_nettype none
`include "gpdl_params.svh"

module gpdl_port
(
    // Clock and reset.
    input  wire logic        CLK_SYS,
    input  wire logic        NRST,
    input  wire logic        PERIPH_NRST,
    // Register bus, write address and data.
    input  wire logic        S_AXI_AWVALID,
    output var  logic        S_AXI_AWREADY,
    input  wire logic [7:0]  S_AXI_AWADDR,
    input  wire logic [2:0]  S_AXI_AWPROT,
    input  wire logic        S_AXI_WVALID,
    output var  logic        S_AXI_WREADY,
    input  wire logic [31:0] S_AXI_WDATA,
    input  wire logic [3:0]  S_AXI_WSTRB,
    // Register bus, write response.
    output var  logic        S_AXI_BVALID,
    input  wire logic        S_AXI_BREADY,
    output var  logic [1:0]  S_AXI_BRESP,
    // Register bus, read.
    input  wire logic        S_AXI_ARVALID,
    output var  logic        S_AXI_ARREADY,
    input  wire logic [7:0]  S_AXI_ARADDR,
    input  wire logic [2:0]  S_AXI_ARPROT,
    output var  logic        S_AXI_RVALID,
    input  wire logic        S_AXI_RREADY,
    output var  logic [31:0] S_AXI_RDATA,
    output var  logic [1:0]  S_AXI_RRESP,
    // Port pins and configuration outputs.
    input  wire logic [15:0] PIN_IN,
    output var  logic [15:0] PIN_OUT,
    output var  logic [15:0] PIN_FREEZE,
    output var  logic [63:0] ALT_FUNC_CODE
);

    gpdl_pkg::gpdl_state_t s_q;
    gpdl_pkg::gpdl_state_t s_d;

    logic nrst_all;
    logic periph_rst_q;

    // Merge byte lanes of a write into an old word.
    // Lanes whose strobe is low keep the old byte.
    function automatic logic [31:0] merge_bytes(
        input logic [31:0] old_word,
        input logic [31:0] new_word,
        input logic [3:0]  strb
    );
        logic [31:0] res;
        res = old_word;
        for (int i = 0; i < 4; i++)
        begin
            if (strb[i])
            begin
                res[i*8 +: 8] = new_word[i*8 +: 8];
            end
        end
        return res;
    endfunction

    // Merge an alternate-function write, skipping frozen pins.
    // Reserved selector codes are stored as written.
    function automatic logic [31:0] merge_af(
        input logic [31:0] old_word,
        input logic [31:0] wr_word,
        input logic [7:0]  frozen
    );
        logic [31:0] res;
        res = old_word;
        for (int p = 0; p < 8; p++)
        begin
            if (!frozen[p])
            begin
                res[p*4 +: 4] = wr_word[p*4 +: 4];
            end
        end
        return res;
    endfunction

    // Clears the byte lane bits so that an offset names a whole word.
    function automatic logic [7:0] word_of(input logic [7:0] a);
        return {a[7:2], 2'b00};
    endfunction

    // Tell whether an offset names a register of this block. Offsets
    // below the input sample belong to registers kept elsewhere.
    function automatic logic is_mapped(input logic [7:0] a);
        logic [7:0] w;
        w = word_of(a);
        return (w >= `GPDL_OFS_INPUT) && (w <= `GPDL_OFS_CLRONLY);
    endfunction

    // Peripheral reset is caught in a flop and joins the system reset.
    // The flop keeps a glitch on the pin from clearing state; the system
    // reset still acts at once.
    always_ff @(posedge CLK_SYS or negedge NRST)
    begin
        if (!NRST)
            periph_rst_q <= 1'b1;
        else
            periph_rst_q <= !PERIPH_NRST;
    end

    assign nrst_all = NRST && !periph_rst_q;

    // Next-state logic for bus, latch, freeze and selectors.
    always_comb
    begin
        logic [7:0]  wa;
        logic [7:0]  ra;
        logic [31:0] wd;
        logic [31:0] full;
        logic [31:0] rd;
        logic        do_wr;
        wa    = 8'h00;
        ra    = 8'h00;
        wd    = 32'h00000000;
        full  = 32'h00000000;
        rd    = 32'h00000000;
        do_wr = 1'b0;
        s_d   = s_q;

        // Input pins pass two flops; the sample refreshes every cycle.
        // Only the second flop reads the first.
        s_d.pin_sync1        = PIN_IN;
        s_d.pin_input_sample = s_q.pin_sync1;

        // Capture write address and data in either order.
        // Neither half is taken while a response waits.
        if (S_AXI_AWVALID && !s_q.wr.aw_full && !s_q.bvalid)
        begin
            s_d.wr.aw_full = 1'b1;
            s_d.wr.aw_addr = S_AXI_AWADDR;
        end
        if (S_AXI_WVALID && !s_q.wr.w_full && !s_q.bvalid)
        begin
            s_d.wr.w_full = 1'b1;
            s_d.wr.w_data = S_AXI_WDATA;
            s_d.wr.w_strb = S_AXI_WSTRB;
        end
        if (s_q.bvalid && S_AXI_BREADY)
            s_d.bvalid = 1'b0;

        // Perform a write once both halves are held.
        do_wr = s_q.wr.aw_full && s_q.wr.w_full && !s_q.bvalid;
        if (do_wr)
        begin
            wa = word_of(s_q.wr.aw_addr);
            wd = merge_bytes(32'h00000000, s_q.wr.w_data, s_q.wr.w_strb);
            s_d.wr.aw_full = 1'b0;
            s_d.wr.w_full  = 1'b0;
            s_d.bvalid     = 1'b1;
            s_d.bresp      = is_mapped(wa) ? `GPDL_RESP_OKAY
                                           : `GPDL_RESP_SLVERR;
            unique case (wa)
                `GPDL_OFS_OUTPUT:
                begin
                    full = merge_bytes({16'h0000, s_q.pin_output_latch},
                                       s_q.wr.w_data, s_q.wr.w_strb);
                    s_d.pin_output_latch = full[15:0];
                end
                `GPDL_OFS_SETCLR:
                begin
                    // Set wins, because it is applied after the clear.
                    s_d.pin_output_latch = (s_q.pin_output_latch
                                            & ~wd[31:16])
                                           | wd[15:0];
                end
                `GPDL_OFS_CLRONLY:
                begin
                    s_d.pin_output_latch = s_q.pin_output_latch
                                           & ~wd[15:0];
                end
                `GPDL_OFS_FREEZE:
                begin
                    // Key steps count only on full words with steady pins.
                    // A partial write restarts the sequence, so it never arms.
                    if (!s_q.freeze_key_bit)
                    begin
                        if (s_q.wr.w_strb == 4'hf)
                        begin
                            s_d.pin_freeze_bits = s_q.wr.w_data[15:0];
                        end
                        else
                        begin
                            full = merge_bytes({16'h0000,
                                               s_q.pin_freeze_bits},
                                               s_q.wr.w_data,
                                               s_q.wr.w_strb);
                            s_d.pin_freeze_bits = full[15:0];
                        end
                        s_d.key_state = gpdl_pkg::KEY_IDLE;
                        // Pins of this step are compared at the next one.
                        s_d.key_pins  = s_q.wr.w_data[15:0];
                        if (s_q.wr.w_strb == 4'hf)
                        begin
                            unique case (s_q.key_state)
                                gpdl_pkg::KEY_IDLE:
                                    if (s_q.wr.w_data[`GPDL_KEY_BIT])
                                        s_d.key_state = gpdl_pkg::KEY_GOT_ONE;
                                gpdl_pkg::KEY_GOT_ONE:
                                    if (!s_q.wr.w_data[`GPDL_KEY_BIT]
                                        && s_q.wr.w_data[15:0]
                                           == s_q.key_pins)
                                        s_d.key_state =
                                            gpdl_pkg::KEY_GOT_ZERO;
                                    else if (s_q.wr.w_data[`GPDL_KEY_BIT])
                                        s_d.key_state = gpdl_pkg::KEY_GOT_ONE;
                                gpdl_pkg::KEY_GOT_ZERO:
                                    if (s_q.wr.w_data[`GPDL_KEY_BIT]
                                        && s_q.wr.w_data[15:0]
                                           == s_q.key_pins)
                                        s_d.freeze_key_bit = 1'b1;
                                    else if (s_q.wr.w_data[`GPDL_KEY_BIT])
                                        s_d.key_state = gpdl_pkg::KEY_GOT_ONE;
                                default:
                                    s_d.key_state = gpdl_pkg::KEY_IDLE;
                            endcase
                        end
                    end
                end
                `GPDL_OFS_AFLOW:
                begin
                    full = merge_bytes(s_q.alt_func_select_low,
                                       s_q.wr.w_data, s_q.wr.w_strb);
                    // Freeze bits bite only once the key is set.
                    s_d.alt_func_select_low = merge_af(
                        s_q.alt_func_select_low, full,
                        s_q.pin_freeze_out[7:0]);
                end
                `GPDL_OFS_AFHIGH:
                begin
                    full = merge_bytes(s_q.alt_func_select_high,
                                       s_q.wr.w_data, s_q.wr.w_strb);
                    s_d.alt_func_select_high = merge_af(
                        s_q.alt_func_select_high, full,
                        s_q.pin_freeze_out[15:8]);
                end
                default:
                begin
                    // Input sample and unmapped offsets ignore writes.
                    s_d.bresp = s_d.bresp;
                end
            endcase
        end

        // Read channel: take one address, answer next cycle.
        // ARREADY is a one-cycle pulse, so one request is taken once.
        s_d.arready = 1'b0;
        if (s_q.rvalid && S_AXI_RREADY)
            s_d.rvalid = 1'b0;
        if (S_AXI_ARVALID && !s_q.arready && !s_q.rvalid)
        begin
            s_d.arready = 1'b1;
            ra = word_of(S_AXI_ARADDR);
            unique case (ra)
                `GPDL_OFS_INPUT:
                    rd = {16'h0000, s_q.pin_input_sample};
                `GPDL_OFS_OUTPUT:
                    rd = {16'h0000, s_q.pin_output_latch};
                `GPDL_OFS_FREEZE:
                    rd = {15'h0000, s_q.freeze_key_bit,
                          s_q.pin_freeze_bits};
                `GPDL_OFS_AFLOW:
                    rd = s_q.alt_func_select_low;
                `GPDL_OFS_AFHIGH:
                    rd = s_q.alt_func_select_high;
                default:
                    rd = 32'h00000000;
            endcase
            s_d.rvalid = 1'b1;
            s_d.rdata  = rd;
            s_d.rresp  = is_mapped(ra) ? `GPDL_RESP_OKAY
                                       : `GPDL_RESP_SLVERR;
        end

        // Ready and frozen-pin outputs are flops that copy the next state.
        s_d.awready        = !s_d.wr.aw_full && !s_d.bvalid;
        s_d.wready         = !s_d.wr.w_full && !s_d.bvalid;
        s_d.pin_freeze_out = s_d.freeze_key_bit ? s_d.pin_freeze_bits
                                                : 16'h0000;
    end

    // State register, cleared by system or peripheral reset.
    // Its reset loads constants only, so the clear needs no other state.
    always_ff @(posedge CLK_SYS or negedge nrst_all)
    begin
        if (!nrst_all)
        begin
            s_q                      <= '0;
            s_q.pin_output_latch     <= `GPDL_RST_OUTPUT;
            s_q.pin_freeze_bits      <= `GPDL_RST_FREEZE;
            s_q.alt_func_select_low  <= `GPDL_RST_AF;
            s_q.alt_func_select_high <= `GPDL_RST_AF;
            s_q.key_state            <= gpdl_pkg::KEY_IDLE;
            s_q.awready              <= 1'b1;
            s_q.wready               <= 1'b1;
        end
        else
        begin
            s_q <= s_d;
        end
    end

    // Outputs straight from state flops.
    // The selector word carries the high pins in its upper half.
    assign S_AXI_AWREADY = s_q.awready;
    assign S_AXI_WREADY  = s_q.wready;
    assign S_AXI_BVALID  = s_q.bvalid;
    assign S_AXI_BRESP   = s_q.bresp;
    assign S_AXI_ARREADY = s_q.arready;
    assign S_AXI_RVALID  = s_q.rvalid;
    assign S_AXI_RDATA   = s_q.rdata;
    assign S_AXI_RRESP   = s_q.rresp;
    assign PIN_OUT       = s_q.pin_output_latch;
    assign PIN_FREEZE    = s_q.pin_freeze_out;
    assign ALT_FUNC_CODE = {s_q.alt_func_select_high,
                            s_q.alt_func_select_low};

endmodule // gpdl_port
`default_nettype wire

// ==== pkg/gpdl_params.svh ====
`ifndef GPDL_PARAMS_SVH
`define GPDL_PARAMS_SVH

// Register byte offsets.
`define GPDL_OFS_INPUT   8'h10
`define GPDL_OFS_OUTPUT  8'h14
`define GPDL_OFS_SETCLR  8'h18
`define GPDL_OFS_FREEZE  8'h1c
`define GPDL_OFS_AFLOW   8'h20
`define GPDL_OFS_AFHIGH  8'h24
`define GPDL_OFS_CLRONLY 8'h28

// Field positions and reset values.
`define GPDL_KEY_BIT     16
`define GPDL_RST_OUTPUT  16'h0000
`define GPDL_RST_FREEZE  16'h0000
`define GPDL_RST_AF      32'h00000000

// Bus responses.
`define GPDL_RESP_OKAY   2'b00
`define GPDL_RESP_SLVERR 2'b10

`endif

// ==== pkg/gpdl_pkg.sv ====
`default_nettype none

package gpdl_pkg;

    // Progress of the freeze key sequence.
    typedef enum logic [1:0] {
        KEY_IDLE,
        KEY_GOT_ONE,
        KEY_GOT_ZERO
    } gpdl_key_t;

    // Write channel pairing of the register bus.
    typedef struct packed {
        logic        aw_full;
        logic [7:0]  aw_addr;
        logic        w_full;
        logic [31:0] w_data;
        logic [3:0]  w_strb;
    } gpdl_wr_t;

    // Whole state of the port block.
    typedef struct packed {
        gpdl_wr_t    wr;
        logic        bvalid;
        logic [1:0]  bresp;
        logic        arready;
        logic        rvalid;
        logic [31:0] rdata;
        logic [1:0]  rresp;
        logic        awready;
        logic        wready;
        logic [15:0] pin_freeze_out;
        logic [15:0] pin_sync1;
        logic [15:0] pin_input_sample;
        logic [15:0] pin_output_latch;
        logic [15:0] pin_freeze_bits;
        logic        freeze_key_bit;
        gpdl_key_t   key_state;
        logic [15:0] key_pins;
        logic [31:0] alt_func_select_low;
        logic [31:0] alt_func_select_high;
    } gpdl_state_t;

endpackage
`default_nettype wire

// ==== tb/gpdl_port_bench.sv ====
`timescale 1ns/1ps
`default_nettype none
module gpdl_port_bench;
    // Clock, resets, pins and bus signals.
    logic        clk = 1'b0;
    logic        nrst = 1'b0;
    logic        periph_nrst = 1'b1;
    logic [15:0] pin_in = 16'ha5c3;
    logic        aw_valid, aw_ready, w_valid, w_ready, b_valid, b_ready;
    logic        ar_valid, ar_ready, r_valid, r_ready;
    logic [7:0]  aw_addr, ar_addr;
    logic [31:0] w_data, r_data, rd_q;
    logic [3:0]  w_strb;
    logic [1:0]  b_resp, r_resp;
    logic [15:0] pin_out, pin_frz;
    logic [63:0] af_code;
    int          n_errors = 0;
    int          compares = 0;
    int          cyc = 0;

    gpdl_port i_gpdl_port
    (
        .CLK_SYS(clk), .NRST(nrst), .PERIPH_NRST(periph_nrst),
        .S_AXI_AWVALID(aw_valid), .S_AXI_AWREADY(aw_ready),
        .S_AXI_AWADDR(aw_addr), .S_AXI_AWPROT(3'h0),
        .S_AXI_WVALID(w_valid), .S_AXI_WREADY(w_ready),
        .S_AXI_WDATA(w_data), .S_AXI_WSTRB(w_strb),
        .S_AXI_BVALID(b_valid), .S_AXI_BREADY(b_ready),
        .S_AXI_BRESP(b_resp), .S_AXI_ARVALID(ar_valid),
        .S_AXI_ARREADY(ar_ready), .S_AXI_ARADDR(ar_addr),
        .S_AXI_ARPROT(3'h0), .S_AXI_RVALID(r_valid),
        .S_AXI_RREADY(r_ready), .S_AXI_RDATA(r_data),
        .S_AXI_RRESP(r_resp), .PIN_IN(pin_in), .PIN_OUT(pin_out),
        .PIN_FREEZE(pin_frz), .ALT_FUNC_CODE(af_code)
    );

    // Clock of 50 ns and a watchdog that ends a hung run.
    always #25 clk = ~clk;
    always @(posedge clk)
    begin
        cyc <= cyc + 1;
        if (cyc == 5000)
        begin
            n_errors++;
            close_out();
        end
    end

    // Prints the counts and the verdict.
    task automatic close_out();
        $display("compares %0d mismatches %0d", compares, n_errors);
        if (n_errors == 0 && compares > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask

    // Compares one value and counts the outcome.
    task automatic chk(input string what, input logic [31:0] exp,
                       input logic [31:0] got);
        compares++;
        if (got !== exp)
        begin
            n_errors++;
            $display("ERROR %s expected %h seen %h", what, exp, got);
        end
    endtask

    // One write; address and data are released as each is taken.
    task automatic wr(input logic [7:0] a, input logic [31:0] d,
                      input logic [3:0] s, input logic [1:0] e);
        @(posedge clk);
        aw_valid <= 1'b1;
        aw_addr <= a;
        w_valid <= 1'b1;
        w_data <= d;
        w_strb <= s;
        b_ready <= 1'b1;
        do
        begin
            @(posedge clk);
            if (aw_valid && aw_ready)
                aw_valid <= 1'b0;
            if (w_valid && w_ready)
                w_valid <= 1'b0;
        end
        while (!b_valid);
        b_ready <= 1'b0;
        chk("write response", {30'h0, e}, {30'h0, b_resp});
    endtask

    // One read; checks the data and the response code.
    task automatic rc(input string n, input logic [7:0] a,
                      input logic [31:0] e, input logic [1:0] re);
        @(posedge clk);
        ar_valid <= 1'b1;
        ar_addr <= a;
        r_ready <= 1'b1;
        do
        begin
            @(posedge clk);
            if (ar_valid && ar_ready)
                ar_valid <= 1'b0;
        end
        while (!r_valid);
        r_ready <= 1'b0;
        chk(n, e, r_data);
        chk("read response", {30'h0, re}, {30'h0, r_resp});
    endtask

    // Main sequence of tests.
    initial
    begin
        {aw_valid, w_valid, b_ready, ar_valid, r_ready} = 5'h0;
        {aw_addr, ar_addr, w_data, w_strb} = 52'h0;
        repeat (12) @(posedge clk);
        nrst <= 1'b1;
        // Let the reset merge and the two pin flops settle first.
        repeat (3) @(posedge clk);
        rc("input", 8'h10, 32'h0000a5c3, 2'b00);
        for (int i = 0; i < 6; i++)
            rc("reset", 8'h14 + 8'(4*i), 32'h0, 2'b00);
        $display("reset test done");
        wr(8'h14, 32'h00001234, 4'hf, 2'b00);
        rc("latch", 8'h14, 32'h00001234, 2'b00);
        wr(8'h10, 32'h0000ffff, 4'hf, 2'b00);
        pin_in <= 16'h3c5a;
        repeat (3) @(posedge clk);
        rc("input", 8'h10, 32'h00003c5a, 2'b00);
        wr(8'h14, 32'h0000ab00, 4'h2, 2'b00);
        rc("latch", 8'h14, 32'h0000ab34, 2'b00);
        $display("latch test done");
        wr(8'h18, 32'h01300101, 4'hf, 2'b00);
        rc("latch", 8'h14, 32'h0000ab05, 2'b00);
        rc("set clear", 8'h18, 32'h0, 2'b00);
        wr(8'h28, 32'h0000000f, 4'hf, 2'b00);
        rc("latch", 8'h14, 32'h0000ab00, 2'b00);
        wr(8'h18, 32'hffff00f0, 4'h3, 2'b00);
        chk("pin out", 32'h0000abf0, {16'h0, pin_out});
        $display("strobe test done");
        wr(8'h20, 32'h76543210, 4'hf, 2'b00);
        wr(8'h24, 32'hfedcba98, 4'hf, 2'b00);
        rc("af low", 8'h20, 32'h76543210, 2'b00);
        chk("af high", 32'hfedcba98, af_code[63:32]);
        $display("selector test done");
        wr(8'h1c, 32'h00010003, 4'hf, 2'b00);
        wr(8'h1c, 32'h00000003, 4'hf, 2'b00);
        wr(8'h1c, 32'h00010001, 4'hf, 2'b00);
        rc("freeze", 8'h1c, 32'h00000001, 2'b00);
        wr(8'h20, 32'h76543201, 4'hf, 2'b00);
        rc("af low", 8'h20, 32'h76543201, 2'b00);
        wr(8'h1c, 32'h00010000, 4'hf, 2'b00);
        rc("freeze", 8'h1c, 32'h0, 2'b00);
        wr(8'h1c, 32'h00010003, 4'hf, 2'b00);
        wr(8'h1c, 32'h00000003, 4'hf, 2'b00);
        wr(8'h1c, 32'h00010003, 4'hf, 2'b00);
        rc("freeze", 8'h1c, 32'h00010003, 2'b00);
        wr(8'h1c, 32'h0, 4'hf, 2'b00);
        rc("freeze", 8'h1c, 32'h00010003, 2'b00);
        wr(8'h20, 32'h0, 4'hf, 2'b00);
        rc("af low", 8'h20, 32'h00000001, 2'b00);
        chk("frozen pins", 32'h00000003, {16'h0, pin_frz});
        $display("freeze test done");
        periph_nrst <= 1'b0;
        @(posedge clk);
        periph_nrst <= 1'b1;
        repeat (3) @(posedge clk);
        rc("freeze", 8'h1c, 32'h0, 2'b00);
        rc("latch", 8'h14, 32'h0, 2'b00);
        rc("unmapped", 8'h2c, 32'h0, 2'b10);
        wr(8'h00, 32'h1, 4'hf, 2'b10);
        $display("peripheral reset test done");
        close_out();
    end
endmodule // gpdl_port_bench
`default_nettype wire

// ==== tb/gpdl_port_props.sv ====
`timescale 1ns/1ps
`default_nettype none
module gpdl_port_props
(
    // Clock and resets.
    input wire logic        CLK_SYS,
    input wire logic        NRST,
    input wire logic        PERIPH_NRST,
    // Register bus.
    input wire logic        S_AXI_AWVALID,
    input wire logic        S_AXI_AWREADY,
    input wire logic [7:0]  S_AXI_AWADDR,
    input wire logic        S_AXI_WVALID,
    input wire logic        S_AXI_WREADY,
    input wire logic [31:0] S_AXI_WDATA,
    input wire logic [3:0]  S_AXI_WSTRB,
    input wire logic        S_AXI_BVALID,
    input wire logic        S_AXI_ARVALID,
    input wire logic        S_AXI_ARREADY,
    input wire logic [7:0]  S_AXI_ARADDR,
    input wire logic        S_AXI_RVALID,
    input wire logic [31:0] S_AXI_RDATA,
    input wire logic [1:0]  S_AXI_RRESP,
    // Port outputs.
    input wire logic [15:0] PIN_OUT,
    input wire logic [15:0] PIN_FREEZE,
    input wire logic [63:0] ALT_FUNC_CODE
);
    logic        prst_q;
    logic [7:0]  wa_q;
    logic [35:0] wd_q;
    logic [63:0] af_mask;
    logic        ar_take;
    logic        wr_full;

    // Remembers the last write beats and the peripheral reset level.
    always_ff @(posedge CLK_SYS)
    begin
        prst_q <= PERIPH_NRST;
        if (S_AXI_AWVALID && S_AXI_AWREADY)
            wa_q <= S_AXI_AWADDR;
        if (S_AXI_WVALID && S_AXI_WREADY)
            wd_q <= {S_AXI_WSTRB, S_AXI_WDATA};
    end

    // Widens each freeze bit to cover its selector nibble.
    always_comb
    begin
        for (int i = 0; i < 16; i++)
            af_mask[4*i +: 4] = {4{PIN_FREEZE[i]}};
    end

    // A read address is taken; the last write had all byte lanes.
    assign ar_take = S_AXI_ARVALID && !S_AXI_ARREADY && !S_AXI_RVALID;
    assign wr_full = wd_q[35:32] == 4'hf;

    default clocking @(posedge CLK_SYS); endclocking
    default disable iff (!NRST || !PERIPH_NRST || !prst_q);

    a_unmapped_err: assert property (ar_take && (S_AXI_ARADDR < 8'h10
        || S_AXI_ARADDR > 8'h2b) |=> S_AXI_RVALID
        && S_AXI_RRESP == 2'b10 && S_AXI_RDATA == 32'h0)
        else $error("unmapped read not refused");
    a_wo_zero: assert property (ar_take && (S_AXI_ARADDR == 8'h18
        || S_AXI_ARADDR == 8'h28) |=> S_AXI_RDATA == 32'h0)
        else $error("strobe register read not zero");
    a_in_upper: assert property (ar_take && S_AXI_ARADDR == 8'h10
        |=> S_AXI_RDATA[31:16] == 16'h0)
        else $error("input sample upper half not zero");
    a_key_lock: assert property (ar_take && S_AXI_ARADDR == 8'h1c
        && PIN_FREEZE != 16'h0 |=> S_AXI_RDATA[16])
        else $error("key bit reads zero while frozen");
    a_freeze_hold: assert property (PIN_FREEZE != 16'h0
        |=> $stable(PIN_FREEZE))
        else $error("frozen pin set changed");
    a_af_frozen: assert property (1'b1 |=> ((ALT_FUNC_CODE
        ^ $past(ALT_FUNC_CODE)) & $past(af_mask)) == 64'h0)
        else $error("frozen selector changed");
    a_setclr_out: assert property ($rose(S_AXI_BVALID) && wr_full
        && wa_q == 8'h18 |-> PIN_OUT
        == (($past(PIN_OUT) & ~wd_q[31:16]) | wd_q[15:0]))
        else $error("set and clear strobes misapplied");
    a_latch_write: assert property ($rose(S_AXI_BVALID) && wr_full
        && wa_q == 8'h14 |-> PIN_OUT == wd_q[15:0])
        else $error("output latch write lost");
    a_clear_only: assert property ($rose(S_AXI_BVALID) && wr_full
        && wa_q == 8'h28 |-> PIN_OUT == ($past(PIN_OUT) & ~wd_q[15:0]))
        else $error("clear-only strobe misapplied");

    c_lock: cover property ($rose(PIN_FREEZE != 16'h0));
    c_setclr: cover property ($rose(S_AXI_BVALID) && wa_q == 8'h18);
    c_unmapped: cover property (ar_take && S_AXI_ARADDR == 8'h2c);
endmodule // gpdl_port_props

bind gpdl_port gpdl_port_props i_gpdl_port_props
(
    .CLK_SYS(CLK_SYS), .NRST(NRST), .PERIPH_NRST(PERIPH_NRST),
    .S_AXI_AWVALID(S_AXI_AWVALID), .S_AXI_AWREADY(S_AXI_AWREADY),
    .S_AXI_AWADDR(S_AXI_AWADDR), .S_AXI_WVALID(S_AXI_WVALID),
    .S_AXI_WREADY(S_AXI_WREADY), .S_AXI_WDATA(S_AXI_WDATA),
    .S_AXI_WSTRB(S_AXI_WSTRB), .S_AXI_BVALID(S_AXI_BVALID),
    .S_AXI_ARVALID(S_AXI_ARVALID), .S_AXI_ARREADY(S_AXI_ARREADY),
    .S_AXI_ARADDR(S_AXI_ARADDR), .S_AXI_RVALID(S_AXI_RVALID),
    .S_AXI_RDATA(S_AXI_RDATA), .S_AXI_RRESP(S_AXI_RRESP),
    .PIN_OUT(PIN_OUT), .PIN_FREEZE(PIN_FREEZE),
    .ALT_FUNC_CODE(ALT_FUNC_CODE)
);
`default_nettype wire
